// ===== pport_seq.sv
// parallel port mode sequencer with apb register slave
// =====================================================
// Functional notes
// - peripheral inactive: status lines are outputs from control reg; host-line edges flag
// - peripheral inactive never starts a forward receive on nselectin low
// - host compatible entry: data pins outputs, idle and request set, no flag
// - host compatible: holding write while idle moves byte at once
// - each move sets nautofd high for primary address, low for alternate
// - strobe low after setup time with good status; hold low, then hold time
// - after hold time: reload if new byte written, else set idle
// - host compatible: perror, nfault, select edges raise status events
// - host negotiation: data pins follow direction and data; software owns handshakes
// - host negotiation: nack, perror, nfault edges raise status events
// - host reserved equals host negotiation without status events
// - peripheral compat: data pins inputs while nselectin low, else software
// - peripheral compat entry sets idle if request flag still set
// - strobe low, nselectin low, flag clear: latch, set flag, busy, then nack
// - nack low for time constant, then release; next clock busy low or idle
// - peripheral compat: select, perror, nfault software; nautofd only readable
// - peripheral compat: nselectin, ninit edges; nautofd, nstrobe only nselectin high
// - host nibble: nautofd low, wait flag clear and nack low, sample low nibble
// - nibble bits busy, perror, select, nfault to 3..0 then 7..4
// - second nibble handshake, then set flag and wait nack high
// - nack rise: next byte if nfault low, else idle and stop
// - host nibble has no status events
// - status events set pending only when status enable bit is one
// - all delays count clocks against software time constant
// - four-bit mode field selects the mode
module pport_seq
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // parallel data pins
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  // handshake pins
  input wire pport_pkg::hs_t hs_in,
  output pport_pkg::hs_t hs_out,
  output pport_pkg::hs_t hs_oe
);
  import pport_pkg::*;

  // =====================================================
  // decoding
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFS_MODE) || (a == OFS_TCONST) || (a == OFS_CTRL) || (a == OFS_DIR)
      || (a == OFS_DATA) || (a == OFS_ALT) || (a == OFS_STATUS);
  endfunction

  function automatic logic is_soft_mode(input logic [3:0] m);
    is_soft_mode = (m == MODE_PLAIN) || (m == MODE_H_NEG) || (m == MODE_H_RSVD)
      || (m == MODE_P_INACT);
  endfunction

  // =====================================================
  // state
  logic [3:0] mode, next_mode, prev_mode;
  logic irq_en, next_irq_en;
  logic [7:0] tconst, next_tconst;
  hs_t ctrl, next_ctrl;
  logic [7:0] dir, next_dir, hold, next_hold, port_data_register, next_ior;
  logic hold_alt, next_hold_alt;
  logic xfer, next_xfer, idle, next_idle, pend, next_pend;
  seq_state_t st, next_st;
  logic [7:0] cnt, next_cnt;
  logic seq_busy, next_seq_busy, seq_nack, next_seq_nack;
  logic seq_strobe, next_seq_strobe, seq_autofd, next_seq_autofd;
  hs_t sync1, sync2, sync3;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] next_data_out, next_data_oe;
  hs_t next_hs_out, next_hs_oe;
  // helpers
  logic acc, wr, rd, entry, cnt_done, stat_evt, soft_pins;
  hs_t edges;
  logic [3:0] nib;
  logic nib_go1;

  // =====================================================
  // next-value logic
  always_comb
  begin
    next_mode = mode;
    next_irq_en = irq_en;
    next_tconst = tconst;
    next_ctrl = ctrl;
    next_dir = dir;
    next_hold = hold;
    next_hold_alt = hold_alt;
    next_ior = port_data_register;
    next_xfer = xfer;
    next_idle = idle;
    next_st = st;
    next_seq_busy = seq_busy;
    next_seq_nack = seq_nack;
    next_seq_strobe = seq_strobe;
    next_seq_autofd = seq_autofd;
    acc = psel & penable & pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    entry = (mode != prev_mode);
    cnt_done = ({1'b0, cnt} + 9'h001) >= {1'b0, tconst};
    edges = sync2 ^ sync3;
    nib = {sync2.busy, sync2.perror, sync2.select, sync2.nfault};
    nib_go1 = (st == ST_NB_LO1) && !xfer && !sync2.nack;
    soft_pins = is_soft_mode(mode) || ((mode == MODE_PERIPH) && sync2.nselectin);

    // apb: one wait state, answer registered
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~addr_ok(paddr);
    next_prdata = 32'h0000_0000;
    if (psel & penable & ~pready & ~pwrite)
    begin
      unique case (paddr)
        OFS_MODE: next_prdata = {26'h000_0000, irq_en, 1'b0, mode};
        OFS_TCONST: next_prdata = {24'h00_0000, tconst};
        OFS_CTRL: next_prdata = {23'h00_0000, ctrl};
        OFS_DIR: next_prdata = {24'h00_0000, dir};
        OFS_DATA: next_prdata = {24'h00_0000, port_data_register};
        OFS_ALT: next_prdata = {24'h00_0000, hold};
        OFS_STATUS: next_prdata = {20'h0_0000, sync2, pend, idle, xfer};
        default: next_prdata = 32'h0000_0000;
      endcase
    end

    // register writes
    if (wr)
    begin
      unique case (paddr)
        OFS_MODE:
        begin
          next_mode = pwdata[3:0];
          next_irq_en = pwdata[MODE_EN_BIT];
        end
        OFS_TCONST: next_tconst = pwdata[7:0];
        OFS_CTRL: next_ctrl = pwdata[8:0];
        OFS_DIR: next_dir = pwdata[7:0];
        OFS_DATA, OFS_ALT:
        begin
          // a write empties the request: the byte now waits in holding
          next_hold = pwdata[7:0];
          next_hold_alt = (paddr == OFS_ALT);
          next_xfer = 1'b0;
        end
        default: ;
      endcase
    end
    // reading the data register takes a received byte
    if (rd && (paddr == OFS_DATA) && ((mode == MODE_PERIPH) || (mode == MODE_H_NIBBLE)))
    begin
      next_xfer = 1'b0;
    end

    // software modes: data register follows pins or holding every clock
    if (soft_pins)
    begin
      next_ior = (dir & hold) | (~dir & data_in);
    end

    // sequencer; hardware sets below win over software clears above
    if (entry)
    begin
      next_st = ST_IDLE;
      next_seq_busy = 1'b0;
      next_seq_nack = 1'b1;
      next_seq_strobe = 1'b1;
      next_seq_autofd = 1'b1;
      if (mode == MODE_H_COMPAT)
      begin
        next_idle = 1'b1;
        next_xfer = 1'b1;
      end
      if ((mode == MODE_PERIPH) && xfer)
      begin
        next_idle = 1'b1;
      end
      if (mode == MODE_H_NIBBLE)
      begin
        next_st = ST_NB_LO1;
        next_seq_autofd = 1'b0;
      end
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          if ((mode == MODE_H_COMPAT) && idle && !xfer)
          begin
            next_ior = hold;
            next_seq_autofd = ~hold_alt;
            next_xfer = 1'b1;
            next_idle = 1'b0;
            next_st = ST_HC_SETUP;
          end
          // inactive mode is deliberately absent here
          else if ((mode == MODE_PERIPH) && !sync2.nstrobe && !sync2.nselectin && !xfer)
          begin
            next_ior = data_in;
            next_xfer = 1'b1;
            next_seq_busy = 1'b1;
            next_st = ST_PC_ACK1;
          end
        end
        ST_HC_SETUP:
        begin
          if (cnt_done && !sync2.busy && !sync2.perror && sync2.select && sync2.nack
            && sync2.nfault)
          begin
            next_seq_strobe = 1'b0;
            next_st = ST_HC_STROBE;
          end
        end
        ST_HC_STROBE:
        begin
          if (cnt_done)
          begin
            next_seq_strobe = 1'b1;
            next_st = ST_HC_HOLD;
          end
        end
        ST_HC_HOLD:
        begin
          if (cnt_done && !xfer)
          begin
            next_ior = hold;
            next_seq_autofd = ~hold_alt;
            next_xfer = 1'b1;
            next_st = ST_HC_SETUP;
          end
          else if (cnt_done)
          begin
            next_idle = 1'b1;
            next_st = ST_IDLE;
          end
        end
        ST_PC_ACK1:
        begin
          next_seq_nack = 1'b0;
          next_st = ST_PC_ACK;
        end
        ST_PC_ACK:
        begin
          if (cnt_done)
          begin
            next_seq_nack = 1'b1;
            next_st = ST_PC_END;
          end
        end
        ST_PC_END:
        begin
          // waits here with busy high until the byte is taken
          if (!xfer)
          begin
            next_seq_busy = 1'b0;
            next_idle = 1'b0;
            next_st = ST_IDLE;
          end
          else
          begin
            next_idle = 1'b1;
          end
        end
        ST_NB_LO1:
        begin
          if (nib_go1)
          begin
            next_ior = {port_data_register[7:4], nib};
            next_seq_autofd = 1'b1;
            next_st = ST_NB_HI1;
          end
        end
        ST_NB_HI1:
        begin
          if (sync2.nack)
          begin
            next_seq_autofd = 1'b0;
            next_st = ST_NB_LO2;
          end
        end
        ST_NB_LO2:
        begin
          if (!sync2.nack)
          begin
            next_ior = {nib, port_data_register[3:0]};
            next_seq_autofd = 1'b1;
            next_xfer = 1'b1;
            next_st = ST_NB_HI2;
          end
        end
        ST_NB_HI2:
        begin
          if (sync2.nack && !sync2.nfault)
          begin
            next_seq_autofd = 1'b0;
            next_st = ST_NB_LO1;
          end
          else if (sync2.nack)
          begin
            next_idle = 1'b1;
            next_st = ST_NB_STOP;
          end
        end
        ST_NB_STOP: ;
        default: next_st = ST_IDLE;
      endcase
    end
    // a holding write in host compatible clears idle only through a move
    next_cnt = (next_st != st) ? 8'h00 : ((cnt == 8'hFF) ? cnt : cnt + 8'h01);

    // status events per mode; nibble and reserved have none
    unique case (mode)
      MODE_P_INACT: stat_evt = |(edges & HOST_LINES);
      MODE_H_COMPAT: stat_evt = edges.perror | edges.nfault | edges.select;
      MODE_H_NEG: stat_evt = edges.nack | edges.perror | edges.nfault;
      MODE_PERIPH: stat_evt = edges.nselectin | edges.ninit
        | (sync2.nselectin & (edges.nautofd | edges.nstrobe));
      default: stat_evt = 1'b0;
    endcase
    // pending is sticky; a new event beats a clear in the same cycle
    next_pend = pend;
    if (wr && (paddr == OFS_STATUS) && pwdata[STAT_PEND_BIT])
    begin
      next_pend = 1'b0;
    end
    if (stat_evt && irq_en)
    begin
      next_pend = 1'b1;
    end

    // pin drive
    next_data_out = port_data_register;
    next_data_oe = 8'h00;
    if (mode == MODE_H_COMPAT)
    begin
      next_data_oe = 8'hFF;
    end
    else if (soft_pins)
    begin
      next_data_oe = dir;
    end
    next_hs_out = ctrl;
    next_hs_oe = 9'h000;
    if ((mode == MODE_PERIPH) || (mode == MODE_P_INACT))
    begin
      next_hs_oe = PERIPH_LINES;
      next_hs_out.busy = ctrl.busy | seq_busy;
      next_hs_out.nack = ctrl.nack & seq_nack;
    end
    if ((mode == MODE_H_NEG) || (mode == MODE_H_RSVD) || (mode == MODE_H_COMPAT)
      || (mode == MODE_H_NIBBLE))
    begin
      next_hs_oe = HOST_LINES;
    end
    if (mode == MODE_H_COMPAT)
    begin
      next_hs_out.nstrobe = seq_strobe;
      next_hs_out.nautofd = seq_autofd;
    end
    if (mode == MODE_H_NIBBLE)
    begin
      next_hs_out.nautofd = seq_autofd;
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mode <= MODE_PLAIN;
      prev_mode <= MODE_PLAIN;
      irq_en <= 1'b0;
      tconst <= TCONST_RST;
      ctrl <= CTRL_RST;
      dir <= DIR_RST;
      hold <= 8'h00;
      hold_alt <= 1'b0;
      port_data_register <= 8'h00;
      xfer <= 1'b0;
      idle <= 1'b0;
      pend <= 1'b0;
      st <= ST_IDLE;
      cnt <= 8'h00;
      seq_busy <= 1'b0;
      seq_nack <= 1'b1;
      seq_strobe <= 1'b1;
      seq_autofd <= 1'b1;
      sync1 <= 9'h1FF;
      sync2 <= 9'h1FF;
      sync3 <= 9'h1FF;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 8'h00;
      hs_out <= CTRL_RST;
      hs_oe <= 9'h000;
    end
    else
    begin
      mode <= next_mode;
      prev_mode <= mode;
      irq_en <= next_irq_en;
      tconst <= next_tconst;
      ctrl <= next_ctrl;
      dir <= next_dir;
      hold <= next_hold;
      hold_alt <= next_hold_alt;
      port_data_register <= next_ior;
      xfer <= next_xfer;
      idle <= next_idle;
      pend <= next_pend;
      st <= next_st;
      cnt <= next_cnt;
      seq_busy <= next_seq_busy;
      seq_nack <= next_seq_nack;
      seq_strobe <= next_seq_strobe;
      seq_autofd <= next_seq_autofd;
      sync1 <= hs_in;
      sync2 <= sync1;
      sync3 <= sync2;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      hs_out <= next_hs_out;
      hs_oe <= next_hs_oe;
    end
  end

  // =====================================================
  // assertions
  AST_HC_OUTPUTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == MODE_H_COMPAT |=> data_oe == 8'hFF)
    else $error("data pins not outputs in host compatible");
  AST_HC_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    entry && mode == MODE_H_COMPAT |=> idle && xfer && (!$rose(pend) || $past(stat_evt)))
    else $error("host compatible entry flags wrong");
  AST_HC_SETUP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(seq_strobe) |-> ({1'b0, $past(cnt)} + 9'h001 >= {1'b0, $past(tconst)})
      && $past(sync2.nack))
    else $error("strobe fell before setup time or with bad status");
  AST_HC_STROBE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st == ST_HC_STROBE && !entry && !cnt_done |=> !seq_strobe)
    else $error("strobe released early");
  AST_HC_AUTOFD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st == ST_HC_SETUP && $past(st) != ST_HC_SETUP && !entry |-> seq_autofd == !hold_alt)
    else $error("nautofd does not match write address");
  AST_PC_ACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(seq_busy) && mode == MODE_PERIPH |=> $fell(seq_nack) && xfer)
    else $error("nack did not follow busy by one clock");
  AST_PC_ACK_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(seq_nack) && !$past(entry)
      |-> {1'b0, $past(cnt)} + 9'h001 >= {1'b0, $past(tconst)})
    else $error("nack pulse shorter than time constant");
  AST_PC_INPUTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == MODE_PERIPH && !sync2.nselectin |=> data_oe == 8'h00)
    else $error("data pins driven while nselectin low");
  AST_INACT_NO_RX: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == MODE_P_INACT |=> !seq_busy || $past(seq_busy))
    else $error("inactive mode started a receive");
  AST_NIB_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nib_go1 && !entry |=> port_data_register[3:0] == $past(nib))
    else $error("low nibble sampled wrong");
  AST_NIB_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == MODE_H_NIBBLE && !pend |=> !pend)
    else $error("status event in host nibble mode");
  AST_PEND_EN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(pend) |-> $past(irq_en) && $past(stat_evt))
    else $error("pending set without enable");
  COV_HC_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st == ST_HC_HOLD ##1 st == ST_IDLE && idle);
  COV_PC_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st == ST_PC_END ##1 st == ST_IDLE);
  COV_NIB_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st == ST_NB_HI2 ##1 st == ST_NB_LO1);
  COV_PEND: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(pend));
endmodule

// ===== pport_pkg.sv
// constants, register map, mode codes and types for the parallel port sequencer
package pport_pkg;
  // =====================================================
  // timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned HC_CRIT_NS = 750;
  localparam int unsigned STD_CRIT_NS = 500;
  localparam int unsigned HC_CRIT_CYC = (HC_CRIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STD_CRIT_CYC = (STD_CRIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TCONST_RST = 8'(HC_CRIT_CYC);
  // =====================================================
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_TCONST = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_DIR = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_ALT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // =====================================================
  // field positions and reset values
  localparam int unsigned MODE_EN_BIT = 5;
  localparam int unsigned STAT_XFER_BIT = 0;
  localparam int unsigned STAT_IDLE_BIT = 1;
  localparam int unsigned STAT_PEND_BIT = 2;
  localparam int unsigned STAT_PIN_LSB = 3;
  localparam logic [8:0] CTRL_RST = 9'h1FF;
  localparam logic [7:0] DIR_RST = 8'h00;
  // =====================================================
  // mode field codes
  localparam logic [3:0] MODE_PLAIN = 4'h0;
  localparam logic [3:0] MODE_PERIPH = 4'h1;
  localparam logic [3:0] MODE_P_INACT = 4'h5;
  localparam logic [3:0] MODE_H_NEG = 4'h8;
  localparam logic [3:0] MODE_H_COMPAT = 4'h9;
  localparam logic [3:0] MODE_H_NIBBLE = 4'hA;
  localparam logic [3:0] MODE_H_RSVD = 4'hD;
  // =====================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_HC_SETUP = 4'b0001,
    ST_HC_STROBE = 4'b0010,
    ST_HC_HOLD = 4'b0011,
    ST_PC_ACK1 = 4'b0100,
    ST_PC_ACK = 4'b0101,
    ST_PC_END = 4'b0110,
    ST_NB_LO1 = 4'b0111,
    ST_NB_HI1 = 4'b1000,
    ST_NB_LO2 = 4'b1001,
    ST_NB_HI2 = 4'b1010,
    ST_NB_STOP = 4'b1011
  } seq_state_t;
  // handshake lines, one bit each, same order as the control register
  typedef struct packed {
    logic busy;
    logic nack;
    logic perror;
    logic nfault;
    logic select;
    logic nstrobe;
    logic nautofd;
    logic nselectin;
    logic ninit;
  } hs_t;
  localparam hs_t PERIPH_LINES = 9'h1F0;
  localparam hs_t HOST_LINES = 9'h00F;
endpackage

// ===== lpt_peer.sv
// far-side model: printer sink, nibble source, host line driver
module lpt_peer
(
  // clock
  input wire logic clk_sys,
  // design pins
  input wire pport_pkg::hs_t hs_out,
  input wire pport_pkg::hs_t hs_oe,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  // bench control
  input wire logic [3:0] host_lines,
  input wire logic [7:0] host_data,
  input wire logic perr,
  input wire logic nib,
  input wire logic [7:0] nib_byte,
  // resolved pin levels
  output pport_pkg::hs_t hs_in,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pport_pkg::*;
  hs_t drv = 9'h0BF;
  hs_t lv;
  logic [1:0] ph = 2'd0;
  logic sprev = 1'b1;
  logic [7:0] got [4];
  logic af [4];
  int cnt = 0;
  int wid = 0;
  int last_wid = 0;
  // ======================================
  // wire levels: the design wins where it drives
  assign lv = (hs_oe & hs_out) | (~hs_oe & drv);
  assign hs_in = lv;
  assign data_in = (data_oe & data_out) | (~data_oe & host_data);
  // ======================================
  // strobe capture and width, nibble handshake
  always @(posedge clk_sys)
  begin
    drv[3:0] <= host_lines;
    if (!lv.nstrobe && sprev)
    begin
      got[cnt[1:0]] <= data_in;
      af[cnt[1:0]] <= lv.nautofd;
      cnt <= cnt + 1;
    end
    if (!lv.nstrobe)
      wid <= sprev ? 1 : wid + 1;
    else if (!sprev)
      last_wid <= wid;
    sprev <= lv.nstrobe;
    if (!nib)
      drv[8:4] <= {1'b0, 1'b1, perr, 1'b1, 1'b1};
    else
      case (ph)
        2'd0: if (!lv.nautofd && lv.nack)
        begin
          {drv.busy, drv.perror, drv.select, drv.nfault} <= nib_byte[3:0];
          drv.nack <= 1'b0;
          ph <= 2'd1;
        end
        2'd1: if (lv.nautofd)
        begin
          drv.nack <= 1'b1;
          ph <= 2'd2;
        end
        2'd2: if (!lv.nautofd)
        begin
          {drv.busy, drv.perror, drv.select, drv.nfault} <= nib_byte[7:4];
          drv.nack <= 1'b0;
          ph <= 2'd3;
        end
        default: if (lv.nautofd)
        begin
          // no more data: nfault high at the closing nack rise
          drv.nfault <= 1'b1;
          drv.nack <= 1'b1;
          ph <= 2'd0;
        end
      endcase
  end
endmodule

// ===== tb_pport_seq.sv
// self-checking bench for the parallel port sequencer
module tb_pport_seq;
  timeunit 1ns;
  timeprecision 1ps;
  import pport_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic [7:0] data_oe;
  hs_t hs_in;
  hs_t hs_out;
  hs_t hs_oe;
  logic [3:0] host_lines = 4'hF;
  logic [7:0] host_data = 8'h00;
  logic perr = 1'b0;
  logic nib = 1'b0;
  logic [7:0] nib_byte = 8'h00;
  logic [31:0] s;
  int err_count = 0;
  int checked = 0;
  always #25 clk_sys = ~clk_sys;
  pport_seq i_pport_seq (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .hs_in(hs_in), .hs_out(hs_out), .hs_oe(hs_oe));
  lpt_peer i_lpt_peer (.clk_sys(clk_sys), .hs_out(hs_out), .hs_oe(hs_oe), .data_out(data_out),
    .data_oe(data_oe), .host_lines(host_lines), .host_data(host_data), .perr(perr),
    .nib(nib), .nib_byte(nib_byte), .hs_in(hs_in), .data_in(data_in));
  // ======================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb transfer; pready and read data taken at the rising edge, no cycle count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask
  task automatic wait_pin(input logic want, input int which, output int n);
    n = 0;
    while ((which ? hs_out.nack : hs_out.busy) !== want && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  // ======================================
  // scenarios
  task automatic t_regs();
    logic e;
    rd(OFS_MODE, s);
    chk(s, 32'h0000_0000);
    rd(OFS_TCONST, s);
    chk(s, 32'(TCONST_RST));
    rd(OFS_CTRL, s);
    chk(s, 32'(CTRL_RST));
    apb(1'b0, 8'h1C, 32'h0000_0000, s, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(s, 32'h0000_0000);
    $display("registers done");
  endtask
  task automatic t_hcomp();
    int n;
    wr(OFS_TCONST, 32'h0000_0004);
    wr(OFS_MODE, 32'h0000_0029);
    rd(OFS_STATUS, s);
    chk(s[2:0], 3'b011);
    chk(data_oe, 8'hFF);
    chk(hs_oe, HOST_LINES);
    // second byte written while the first is still in its setup time
    wr(OFS_DATA, 32'h0000_00A5);
    wr(OFS_ALT, 32'h0000_003C);
    n = 0;
    s = 32'h0000_0000;
    while (s[1] !== 1'b1 && n < 100)
    begin
      rd(OFS_STATUS, s);
      n++;
    end
    chk(i_lpt_peer.cnt, 2);
    chk({i_lpt_peer.af[0], i_lpt_peer.got[0]}, 9'h1A5);
    chk({i_lpt_peer.af[1], i_lpt_peer.got[1]}, 9'h03C);
    chk(i_lpt_peer.last_wid, 4);
    $display("host compatible done");
  endtask
  task automatic t_irq();
    logic [7:0] m [5] = '{8'h29, 8'h09, 8'h28, 8'h2D, 8'h25};
    logic x [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    // busy low by software, so peripheral modes show the control value
    wr(OFS_CTRL, 32'h0000_00FF);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_MODE, {24'h00_0000, m[i]});
      wr(OFS_STATUS, 32'h0000_0004);
      @(posedge clk_sys);
      perr <= ~perr;
      host_lines <= host_lines ^ 4'h1;
      repeat (6) @(posedge clk_sys);
      rd(OFS_STATUS, s);
      chk(s[2], x[i]);
    end
    chk(hs_oe, PERIPH_LINES);
    chk(hs_out & PERIPH_LINES, 9'h0F0);
    $display("status events done");
  endtask
  task automatic t_periph();
    int n;
    wr(OFS_MODE, 32'h0000_0021);
    rd(OFS_STATUS, s);
    chk(s[1], 1'b1);
    rd(OFS_DATA, s);
    @(posedge clk_sys);
    host_data <= 8'h5A;
    host_lines <= 4'b0101;
    wait_pin(1'b1, 0, n);
    chk(data_oe, 8'h00);
    wait_pin(1'b0, 1, n);
    wait_pin(1'b1, 1, n);
    chk(n, 4);
    @(posedge clk_sys);
    host_lines <= 4'b1101;
    // pins stay inputs while nselectin is low, whatever direction says
    wr(OFS_DIR, 32'h0000_00FF);
    chk(data_oe, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk(hs_out.busy, 1'b1);
    rd(OFS_STATUS, s);
    chk(s[1:0], 2'b11);
    rd(OFS_DATA, s);
    chk(s, 32'h0000_005A);
    repeat (6) @(posedge clk_sys);
    chk(hs_out.busy, 1'b0);
    $display("peripheral compatible done");
  endtask
  task automatic t_nibble();
    int n;
    nib_byte <= 8'h96;
    nib <= 1'b1;
    wr(OFS_MODE, 32'h0000_002A);
    wr(OFS_STATUS, 32'h0000_0004);
    n = 0;
    s = 32'h0000_0000;
    while (s[1] !== 1'b1 && n < 100)
    begin
      rd(OFS_STATUS, s);
      n++;
    end
    chk(s[2:0], 3'b011);
    rd(OFS_DATA, s);
    chk(s, 32'h0000_0096);
    $display("host nibble done");
  endtask
  // ======================================
  // verdict and run control
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_hcomp();
    t_irq();
    t_periph();
    t_nibble();
    end_of_test();
  end
endmodule
